// *** eswl_pkg.sv ***
// Shared constants and types for the edge selectable word latch.
// Assumes one 100 MHz clock and an Avalon-MM slave port with waitrequest.
package eswl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam int ESWL_AW = 5;
  localparam logic [4:0] ESWL_CTRL_OFS = 5'h00;
  localparam logic [4:0] ESWL_INIT_WORD_OFS = 5'h04;
  localparam logic [4:0] ESWL_INIT_FLOAT_OFS = 5'h08;
  localparam logic [4:0] ESWL_WORD_OFS = 5'h0c;
  localparam logic [4:0] ESWL_FLOAT_OFS = 5'h10;
  localparam logic [4:0] ESWL_STATUS_OFS = 5'h14;
  localparam logic [4:0] ESWL_CMD_OFS = 5'h18;

  // ==========================================================
  // Field positions
  localparam int ESWL_MODE_LSB = 0;
  localparam int ESWL_CONN_BIT = 3;
  localparam int ESWL_RETAIN_BIT = 4;
  localparam int ESWL_LOADINIT_BIT = 5;
  localparam int ESWL_CMD_POWER_BIT = 0;
  localparam int ESWL_CMD_PROJECT_BIT = 1;
  localparam int ESWL_ST_RUN_BIT = 0;
  localparam int ESWL_ST_SAVED_BIT = 1;
  localparam int ESWL_ST_LEVEL_BIT = 2;

  // ==========================================================
  // Capture modes
  localparam logic [2:0] ESWL_MODE_HIGH = 3'h0;
  localparam logic [2:0] ESWL_MODE_LOW = 3'h1;
  localparam logic [2:0] ESWL_MODE_RISE = 3'h2;
  localparam logic [2:0] ESWL_MODE_FALL = 3'h3;
  localparam logic [2:0] ESWL_MODE_BOTH = 3'h4;

  // Kinds of value on the data input
  localparam logic [1:0] ESWL_KIND_BIN = 2'h0;
  localparam logic [1:0] ESWL_KIND_WORD = 2'h1;
  localparam logic [1:0] ESWL_KIND_ANALOG = 2'h2;
  localparam logic [1:0] ESWL_KIND_LONG = 2'h3;

  // ==========================================================
  // Reset values and float constants
  localparam logic [2:0] ESWL_MODE_RST = ESWL_MODE_HIGH;
  localparam logic ESWL_CONN_RST = 1'b1;
  localparam logic [15:0] ESWL_INIT_WORD_RST = 16'h0000;
  localparam logic [31:0] ESWL_INIT_FLOAT_RST = 32'h0000_0000;
  localparam logic [31:0] ESWL_FLOAT_ONE = 32'h3f80_0000;
  localparam logic [7:0] ESWL_BIAS = 8'h7f;

  // ==========================================================
  // Types
  typedef enum logic {ESWL_BOOT, ESWL_RUN} eswl_phase_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [31:0] value;
  } eswl_data_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ESWL_AW-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } eswl_avs_req_t;

  typedef struct packed {
    logic prev;
  } eswl_edge_state_t;

  typedef struct packed {
    eswl_phase_t phase;
    logic new_proj;
    logic [2:0] mode;
    logic conn;
    logic retain;
    logic load_init;
    logic [15:0] init_word;
    logic [31:0] init_float;
    logic [15:0] word_holder;
    logic [31:0] float_holder;
    logic [15:0] saved_word;
    logic [31:0] saved_float;
    logic saved_valid;
    logic waitreq;
    logic [31:0] rdata;
  } eswl_core_state_t;

endpackage : eswl_pkg

// *** eswl_edge.sv ***
// Latch-control qualifier: turns the control level into a capture strobe.
// Assumes the control input comes from logic on the same clock.
`timescale 1ns/100ps
module eswl_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control and mode
  input wire logic latch_i,
  input wire logic connected_i,
  input wire logic [2:0] mode_i,
  // Result
  output logic capture_o,
  output logic level_o
);
  import eswl_pkg::*;

  eswl_edge_state_t s_q;
  eswl_edge_state_t s_d;
  logic lat_v;

  // ==========================================================
  // Qualification
  // A floating control reads as low
  assign lat_v = latch_i & connected_i;
  assign level_o = lat_v;

  // Previous sample kept for edge detection
  always_comb begin
    s_d = s_q;
    s_d.prev = lat_v;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Capture condition per mode; unknown codes never capture
  always_comb begin
    case (mode_i)
      ESWL_MODE_HIGH: capture_o = lat_v;
      ESWL_MODE_LOW: capture_o = !lat_v;
      ESWL_MODE_RISE: capture_o = lat_v & !s_q.prev;
      ESWL_MODE_FALL: capture_o = !lat_v & s_q.prev;
      ESWL_MODE_BOTH: capture_o = lat_v ^ s_q.prev;
      default: capture_o = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_RISE: assert property ((mode_i == ESWL_MODE_RISE) |-> (capture_o == (lat_v && !$past(lat_v))))
    else $error("rise capture mismatch");
  AST_FALL: assert property ((mode_i == ESWL_MODE_FALL) |-> (capture_o == (!lat_v && $past(lat_v))))
    else $error("fall capture mismatch");
  AST_BOTH: assert property ((mode_i == ESWL_MODE_BOTH) |-> (capture_o == (lat_v != $past(lat_v))))
    else $error("both-edge capture mismatch");
  AST_UNCONN: assert property ((!connected_i && mode_i == ESWL_MODE_HIGH) |-> !capture_o)
    else $error("unconnected control captured");

endmodule : eswl_edge

// *** eswl_convert.sv ***
// Input casting: maps any input kind onto the word and float holders.
// Assumes IEEE single format for analog values; purely combinational.
`timescale 1ns/100ps
module eswl_convert (
  // Incoming value
  input wire eswl_pkg::eswl_data_t data_i,
  // Cast results
  output logic [15:0] word_o,
  output logic [31:0] float_o
);
  import eswl_pkg::*;

  logic [7:0] exp_v;
  logic [39:0] int_v;
  logic [31:0] mag_v;
  logic [31:0] norm_v;
  logic [4:0] msb_v;
  logic neg_v;

  // ==========================================================
  // Float to integer, truncating toward zero
  always_comb begin
    exp_v = data_i.value[30:23];
    int_v = '0;
    if (exp_v >= ESWL_BIAS && exp_v <= ESWL_BIAS + 8'd23) begin
      int_v = {16'h0000, 1'b1, data_i.value[22:0]} >> (ESWL_BIAS + 8'd23 - exp_v);
    end else if (exp_v > ESWL_BIAS + 8'd23 && exp_v <= ESWL_BIAS + 8'd38) begin
      int_v = {16'h0000, 1'b1, data_i.value[22:0]} << (exp_v - ESWL_BIAS - 8'd23);
    end
    if (data_i.value[31]) begin
      int_v = 40'(-int_v);
    end
  end

  // ==========================================================
  // Integer to float; low bits beyond 24 are cut, not rounded
  always_comb begin
    neg_v = (data_i.kind == ESWL_KIND_LONG) && data_i.value[31];
    if (data_i.kind == ESWL_KIND_WORD) begin
      mag_v = {16'h0000, data_i.value[15:0]};
    end else begin
      mag_v = neg_v ? 32'(-data_i.value) : data_i.value;
    end
    msb_v = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag_v[i]) begin
        msb_v = 5'(i);
      end
    end
    norm_v = mag_v << (5'd31 - msb_v);
  end

  // Results per kind; wider integers keep their low word
  always_comb begin
    case (data_i.kind)
      ESWL_KIND_BIN: begin
        word_o = {15'h0000, data_i.value[0]};
        float_o = data_i.value[0] ? ESWL_FLOAT_ONE : 32'h0000_0000;
      end
      ESWL_KIND_ANALOG: begin
        word_o = int_v[15:0];
        float_o = data_i.value;
      end
      default: begin
        word_o = data_i.value[15:0];
        float_o = (mag_v == 32'h0000_0000) ? 32'h0000_0000 :
                  {neg_v, ESWL_BIAS + {3'b000, msb_v}, norm_v[30:8]};
      end
    endcase
  end

endmodule : eswl_convert

// *** eswl_latch.sv ***
// Edge selectable word latch: word and float holders with startup,
// retention and an Avalon-MM register port.
// Assumes data and control come from logic on the same clock.
`timescale 1ns/100ps

module eswl_latch (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Value and control
  input wire eswl_pkg::eswl_data_t data_in_i,
  input wire logic latch_i,
  // Register port
  input wire eswl_pkg::eswl_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Held values
  output logic [15:0] word_value_out_o,
  output logic [31:0] float_value_out_o
);
  import eswl_pkg::*;

  eswl_core_state_t s_q;
  eswl_core_state_t s_d;
  logic capture;
  logic level;
  logic [15:0] conv_word;
  logic [31:0] conv_float;
  logic req;
  logic wr_take;
  logic restart;
  logic use_saved;
  logic [31:0] rd_v;

  // ==========================================================
  // Sub-blocks
  eswl_edge u_edge (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .latch_i(latch_i),
    .connected_i(s_q.conn),
    .mode_i(s_q.mode),
    .capture_o(capture),
    .level_o(level)
  );

  eswl_convert u_conv (
    .data_i(data_in_i),
    .word_o(conv_word),
    .float_o(conv_float)
  );

  // ==========================================================
  // Bus helpers
  // Byte-lane merge for partial writes
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be_v
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be_v[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // A request is answered one cycle after it is seen; a write is taken then and lands at the next edge
  assign req = avs_req_i.read | avs_req_i.write;
  assign wr_take = avs_req_i.write & !s_q.waitreq;
  assign restart = wr_take && (avs_req_i.address == ESWL_CMD_OFS) &&
                   avs_req_i.byteenable[0] &&
                   (avs_req_i.writedata[ESWL_CMD_POWER_BIT] ||
                    avs_req_i.writedata[ESWL_CMD_PROJECT_BIT]);

  // Saved value is used when retention is on and holds a valid copy, unless a new project asks for the initial one
  assign use_saved = s_q.retain & s_q.saved_valid &
                     !(s_q.new_proj & s_q.load_init);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_v = 32'h0000_0000;
    if (avs_req_i.address == ESWL_CTRL_OFS) begin
      rd_v[ESWL_MODE_LSB +: 3] = s_q.mode;
      rd_v[ESWL_CONN_BIT] = s_q.conn;
      rd_v[ESWL_RETAIN_BIT] = s_q.retain;
      rd_v[ESWL_LOADINIT_BIT] = s_q.load_init;
    end else if (avs_req_i.address == ESWL_INIT_WORD_OFS) begin
      rd_v[15:0] = s_q.init_word;
    end else if (avs_req_i.address == ESWL_INIT_FLOAT_OFS) begin
      rd_v = s_q.init_float;
    end else if (avs_req_i.address == ESWL_WORD_OFS) begin
      rd_v[15:0] = s_q.word_holder;
    end else if (avs_req_i.address == ESWL_FLOAT_OFS) begin
      rd_v = s_q.float_holder;
    end else if (avs_req_i.address == ESWL_STATUS_OFS) begin
      rd_v[ESWL_ST_RUN_BIT] = (s_q.phase == ESWL_RUN);
      rd_v[ESWL_ST_SAVED_BIT] = s_q.saved_valid;
      rd_v[ESWL_ST_LEVEL_BIT] = level;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Bus handshake: waitrequest drops for exactly one cycle
    s_d.waitreq = 1'b1;
    if (req && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = rd_v;
    end
    // Register writes, lane by lane
    if (wr_take) begin
      if (avs_req_i.address == ESWL_CTRL_OFS) begin
        if (avs_req_i.byteenable[0]) begin
          s_d.mode = avs_req_i.writedata[ESWL_MODE_LSB +: 3];
          s_d.conn = avs_req_i.writedata[ESWL_CONN_BIT];
          s_d.retain = avs_req_i.writedata[ESWL_RETAIN_BIT];
          s_d.load_init = avs_req_i.writedata[ESWL_LOADINIT_BIT];
        end
      end else if (avs_req_i.address == ESWL_INIT_WORD_OFS) begin
        s_d.init_word = 16'(be_merge({16'h0000, s_q.init_word}, avs_req_i.writedata,
                                     avs_req_i.byteenable));
      end else if (avs_req_i.address == ESWL_INIT_FLOAT_OFS) begin
        s_d.init_float = be_merge(s_q.init_float, avs_req_i.writedata,
                                  avs_req_i.byteenable);
      end
    end
    // Holder sequencing
    case (s_q.phase)
      ESWL_BOOT: begin
        // Startup load happens before the first capture is allowed
        if (use_saved) begin
          s_d.word_holder = s_q.saved_word;
          s_d.float_holder = s_q.saved_float;
        end else begin
          s_d.word_holder = s_q.init_word;
          s_d.float_holder = s_q.init_float;
        end
        s_d.new_proj = 1'b0;
        s_d.phase = ESWL_RUN;
      end
      ESWL_RUN: begin
        // Data is sampled in the very cycle the strobe is true
        if (capture) begin
          s_d.word_holder = conv_word;
          s_d.float_holder = conv_float;
        end
        // Power return or project download restarts the holder
        if (restart) begin
          s_d.phase = ESWL_BOOT;
          s_d.new_proj = avs_req_i.writedata[ESWL_CMD_PROJECT_BIT];
        end
      end
      default: begin
        s_d.phase = ESWL_BOOT;
      end
    endcase
    // Retained copy tracks the holder while retention is on
    if (s_d.retain) begin
      s_d.saved_word = s_d.word_holder;
      s_d.saved_float = s_d.float_holder;
      s_d.saved_valid = 1'b1;
    end
  end

  // ==========================================================
  // State register
  // The retained copy models non-volatile storage; a hard reset still
  // clears it, so only the restart command exercises retention.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.phase <= ESWL_BOOT;
      s_q.mode <= ESWL_MODE_RST;
      s_q.conn <= ESWL_CONN_RST;
      s_q.init_word <= ESWL_INIT_WORD_RST;
      s_q.init_float <= ESWL_INIT_FLOAT_RST;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign word_value_out_o = s_q.word_holder;
  assign float_value_out_o = s_q.float_holder;
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_HIGH_CAPTURE: assert property (
    (s_q.phase == ESWL_RUN && s_q.mode == ESWL_MODE_HIGH && level)
    |=> (word_value_out_o == $past(conv_word)))
    else $error("high level did not capture");

  AST_LOW_CAPTURE: assert property (
    (s_q.phase == ESWL_RUN && s_q.mode == ESWL_MODE_LOW && !level)
    |=> (word_value_out_o == $past(conv_word)))
    else $error("low level did not capture");

  AST_HOLD: assert property (
    (s_q.phase == ESWL_RUN && !capture) |=> $stable(word_value_out_o))
    else $error("word changed without capture");

  AST_FLOAT_CAPTURE: assert property (
    (s_q.phase == ESWL_RUN && capture)
    |=> (float_value_out_o == $past(conv_float)))
    else $error("float holder missed capture");

  AST_BOOT_INIT: assert property (
    (s_q.phase == ESWL_BOOT && !use_saved)
    |=> (word_value_out_o == $past(s_q.init_word)) && (s_q.phase == ESWL_RUN))
    else $error("startup did not load initial value");

  AST_RESTORE: assert property (
    (s_q.phase == ESWL_BOOT && use_saved)
    |=> (word_value_out_o == $past(s_q.saved_word)))
    else $error("retained value not restored");

  AST_NEWPROJ_INIT: assert property (
    (s_q.phase == ESWL_BOOT && s_q.new_proj && s_q.load_init)
    |=> (word_value_out_o == $past(s_q.init_word)))
    else $error("new project ignored initial value");

  AST_LONG_TRUNC: assert property (
    (s_q.phase == ESWL_RUN && capture && data_in_i.kind == ESWL_KIND_LONG)
    |=> (word_value_out_o == $past(data_in_i.value[15:0])))
    else $error("long input not cut to low word");

  AST_BUS_ACK: assert property (
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest answer timing wrong");

  // ==========================================================
  // Mode, casting and retention checks

  // Rise mode stores the data seen at the zero-to-one edge
  AST_RISE_WORD: assert property (
    (s_q.phase == ESWL_RUN && s_q.mode == ESWL_MODE_RISE && level && !$past(level))
    |=> (word_value_out_o == $past(conv_word)))
    else $error("rise edge did not store data");

  // Fall mode stores the data seen at the one-to-zero edge
  AST_FALL_WORD: assert property (
    (s_q.phase == ESWL_RUN && s_q.mode == ESWL_MODE_FALL && !level && $past(level))
    |=> (word_value_out_o == $past(conv_word)))
    else $error("fall edge did not store data");

  // Both-edge mode stores on any change of the effective level
  AST_BOTH_WORD: assert property (
    (s_q.phase == ESWL_RUN && s_q.mode == ESWL_MODE_BOTH && level != $past(level))
    |=> (word_value_out_o == $past(conv_word)))
    else $error("edge change did not store data");

  // Spare mode codes must stay inert, whatever the control does
  AST_UNUSED_MODE: assert property (
    (s_q.mode > ESWL_MODE_BOTH)
    |-> !capture)
    else $error("spare mode code captured");

  // A disconnected control reads low, so level modes see zero
  AST_UNCONN_LEVEL: assert property (
    (!s_q.conn)
    |-> !level)
    else $error("unconnected control not low");

  // The startup load takes exactly one cycle
  AST_BOOT_ONE: assert property (
    (s_q.phase == ESWL_BOOT)
    |=> (s_q.phase == ESWL_RUN))
    else $error("startup phase did not end");

  // A full-lane write to the initial word lands in its register one cycle later
  AST_INIT_WRITE: assert property (
    (wr_take && avs_req_i.address == ESWL_INIT_WORD_OFS && avs_req_i.byteenable == 4'hf)
    |=> (s_q.init_word == $past(avs_req_i.writedata[15:0])))
    else $error("initial word write lost");

  // The retained copy never lags the holder while retention is on
  AST_SAVED_TRACK: assert property (
    s_q.retain
    |-> (s_q.saved_valid && s_q.saved_word == word_value_out_o))
    else $error("retained copy out of step");

  // A restart remembers whether it came from a new project
  AST_RESTART_BOOT: assert property (
    (s_q.phase == ESWL_RUN && restart)
    |=> (s_q.phase == ESWL_BOOT && s_q.new_proj == $past(avs_req_i.writedata[ESWL_CMD_PROJECT_BIT])))
    else $error("restart not taken");

  // A binary input lands as zero or one in the word
  AST_BIN_CAST: assert property (
    (s_q.phase == ESWL_RUN && capture && data_in_i.kind == ESWL_KIND_BIN)
    |=> (word_value_out_o == {15'h0000, $past(data_in_i.value[0])}))
    else $error("binary input not cast to 0 or 1");

  // An analog input passes into the float holder bit for bit
  AST_ANALOG_FLOAT: assert property (
    (s_q.phase == ESWL_RUN && capture && data_in_i.kind == ESWL_KIND_ANALOG)
    |=> (float_value_out_o == $past(data_in_i.value)))
    else $error("analog input altered in float holder");

  // A word read returns the stored word as it stood when the request was first seen
  AST_READ_WORD: assert property (
    (avs_req_i.read && avs_waitrequest_o && avs_req_i.address == ESWL_WORD_OFS)
    |=> (avs_readdata_o == {16'h0000, $past(word_value_out_o)}))
    else $error("word read returned wrong value");

  // The word moves only after a capture or a startup load
  AST_WORD_SOURCE: assert property (
    $changed(word_value_out_o)
    |-> ($past(capture) || $past(s_q.phase) == ESWL_BOOT))
    else $error("word changed with no cause");

endmodule : eswl_latch

// *** eswl_src_model.sv ***
// Upstream source model: drives the data input and the latch-control input.
// Assumes the bench calls its task; every change lands just after a rising edge.
`timescale 1ns/100ps
module eswl_src_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Driven value and control
  output eswl_pkg::eswl_data_t data_o,
  output logic latch_o
);
  import eswl_pkg::*;

  // ==========================================================
  // Drive state
  eswl_data_t data_q = '0;
  logic latch_q = 1'b0;

  // Outputs are the registered drive values
  assign data_o = data_q;
  assign latch_o = latch_q;

  // Value and control move together right after an edge and then stay put
  // until the next call, so the capturing edge always sees a settled value.
  task automatic drive(input logic [1:0] kind, input logic [31:0] value, input logic lat);
    @(posedge clk_i);
    data_q <= '{kind: kind, value: value};
    latch_q <= lat;
  endtask : drive
endmodule : eswl_src_model

// *** eswl_tb.sv ***
// Self-checking bench for the word latch: bus tasks, scenarios, verdict.
// Assumes the source model drives data and control; the bench owns the bus.
`timescale 1ns/100ps
module testbench;
  import eswl_pkg::*;

  // ==========================================================
  // Signals and counters
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  eswl_avs_req_t req = '0;
  eswl_data_t data_w;
  logic latch_w;
  logic [31:0] rdata_w;
  logic wait_w;
  logic [15:0] word_w;
  logic [31:0] float_w;
  int err_total = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;

  // ==========================================================
  // Clock, instances and hang guard
  always #5 clk_i = ~clk_i;

  eswl_src_model src (.clk_i(clk_i), .resetn_i(resetn_i), .data_o(data_w), .latch_o(latch_w));

  eswl_latch uut (.clk_i(clk_i), .resetn_i(resetn_i), .data_in_i(data_w), .latch_i(latch_w),
    .avs_req_i(req), .avs_readdata_o(rdata_w), .avs_waitrequest_o(wait_w),
    .word_value_out_o(word_w), .float_value_out_o(float_w));

  // The whole run needs well under a thousand cycles; this ceiling is generous
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      err_total++;
      print_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Waitrequest and read data are taken as the rising edge sees them, before
  // the design's flops move; the request is released only after that edge.
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{read: !wr_en, write: wr_en, address: a, byteenable: 4'hf, writedata: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_w !== 1'b0 && n < 50);
    rd = rdata_w;
    if (wait_w !== 1'b0) chk("bus_ack", 32'h0, 32'h1);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(nm, rd, exp);
  endtask : rchk

  // One capture opportunity: drive, let the capturing edge pass, settle
  task automatic step(input logic [1:0] kind, input logic [31:0] value, input logic lat);
    src.drive(kind, value, lat);
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic restart(input logic [31:0] cmd, input logic [15:0] exp);
    wr(ESWL_CMD_OFS, cmd);
    repeat (3) @(posedge clk_i);
    #1;
    chk("word_restart", {16'h0, word_w}, {16'h0, exp});
  endtask : restart

  task automatic cast1(input logic [1:0] kind, input logic [31:0] v, input logic [15:0] ew, input logic [31:0] ef);
    step(kind, v, 1'b1);
    chk("word_cast", {16'h0, word_w}, {16'h0, ew});
    chk("float_cast", float_w, ef);
  endtask : cast1

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("word_in_reset", {16'h0, word_w}, 32'h0);
    chk("wait_in_reset", {31'h0, wait_w}, 32'h1);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("word_boot", {16'h0, word_w}, 32'h0);
    chk("float_boot", float_w, 32'h0);
    rchk("ctrl_rst", ESWL_CTRL_OFS, 32'h8);
    rchk("init_rst", ESWL_INIT_WORD_OFS, 32'h0);
    rchk("unmapped", 5'h1c, 32'h0);
    wr(ESWL_WORD_OFS, 32'hffff);
    rchk("word_ro", ESWL_WORD_OFS, 32'h0);
  endtask : t_reset

  // Every mode code, the unused code 5 too, against one control pattern;
  // the expected word is worked out here from the previous control level.
  task automatic t_modes();
    logic [7:0] pat;
    logic prev;
    logic cap;
    logic [15:0] exp;
    pat = 8'b1001_0110;
    for (int m = 0; m < 6; m++) begin
      wr(ESWL_CTRL_OFS, 32'h8);
      step(ESWL_KIND_WORD, 32'h00a5, 1'b1);
      step(ESWL_KIND_WORD, 32'h00a5, 1'b0);
      wr(ESWL_CTRL_OFS, 32'h8 | 32'(m));
      exp = 16'h00a5;
      prev = 1'b0;
      for (int i = 0; i < 8; i++) begin
        step(ESWL_KIND_WORD, 32'h1000 + 32'(m * 16 + i), pat[i]);
        case (m)
          0: cap = pat[i];
          1: cap = !pat[i];
          2: cap = pat[i] & !prev;
          3: cap = !pat[i] & prev;
          4: cap = pat[i] ^ prev;
          default: cap = 1'b0;
        endcase
        if (cap) exp = 16'h1000 + 16'(m * 16 + i);
        prev = pat[i];
        chk("word_mode", {16'h0, word_w}, {16'h0, exp});
      end
    end
    rchk("word_reg", ESWL_WORD_OFS, {16'h0, exp});
  endtask : t_modes

  task automatic t_conn();
    wr(ESWL_CTRL_OFS, 32'h0);
    step(ESWL_KIND_WORD, 32'h2222, 1'b1);
    chk("word_unconn_high", {16'h0, word_w}, 32'h00a5);
    rchk("status_unconn", ESWL_STATUS_OFS, 32'h1);
    wr(ESWL_CTRL_OFS, 32'h1);
    step(ESWL_KIND_WORD, 32'h3333, 1'b1);
    chk("word_unconn_low", {16'h0, word_w}, 32'h3333);
  endtask : t_conn

  task automatic t_cast();
    wr(ESWL_CTRL_OFS, 32'h8);
    cast1(ESWL_KIND_BIN, 32'h0, 16'h0000, 32'h0000_0000);
    cast1(ESWL_KIND_BIN, 32'h1, 16'h0001, 32'h3f80_0000);
    cast1(ESWL_KIND_ANALOG, 32'h4145_70a4, 16'h000c, 32'h4145_70a4);
    cast1(ESWL_KIND_ANALOG, 32'h42c5_cccd, 16'h0062, 32'h42c5_cccd);
    cast1(ESWL_KIND_LONG, 32'h0000_fde8, 16'hfde8, 32'h477d_e800);
    cast1(ESWL_KIND_LONG, 32'h0001_3880, 16'h3880, 32'h479c_4000);
    cast1(ESWL_KIND_WORD, 32'h0000_000c, 16'h000c, 32'h4140_0000);
  endtask : t_cast

  // Restarts with latch low in high mode, so nothing but the boot load moves
  task automatic t_retain();
    wr(ESWL_INIT_WORD_OFS, 32'h1234);
    wr(ESWL_INIT_FLOAT_OFS, 32'h4049_0fdb);
    wr(ESWL_CTRL_OFS, 32'h18);
    step(ESWL_KIND_WORD, 32'h0abc, 1'b1);
    step(ESWL_KIND_WORD, 32'h0abc, 1'b0);
    restart(32'h1, 16'h0abc);
    rchk("status_saved", ESWL_STATUS_OFS, 32'h3);
    restart(32'h2, 16'h0abc);
    wr(ESWL_CTRL_OFS, 32'h38);
    restart(32'h1, 16'h0abc);
    restart(32'h2, 16'h1234);
    step(ESWL_KIND_WORD, 32'h0777, 1'b1);
    step(ESWL_KIND_WORD, 32'h0777, 1'b0);
    wr(ESWL_CTRL_OFS, 32'h08);
    restart(32'h1, 16'h1234);
    chk("float_init", float_w, 32'h4049_0fdb);
  endtask : t_retain

  // ==========================================================
  // Verdict and main sequence
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    t_reset();
    t_modes();
    t_conn();
    t_cast();
    t_retain();
    t_reset();
    print_verdict();
  end
endmodule : testbench
